//--- logic/tife_core.sv
// Operation
// - Timer A, four pins and the event counter set flags in pending one.
// - Pending one bit 7 sets when timer A wraps from its top value to zero.
// - Writing zero to the timer A flag clears it.
// - Enable one bit 5 passes or blocks the timer A request.
// - Transition, converter, timer G, F halves, C, counter set pending two.
// - The timer C flag sets on both overflow and underflow of timer C.
// - Writing zero to the timer C flag clears it.
// - Enable two bit 1 passes or blocks the timer C request.
`timescale 1ns/1ps
`include "tife_params.svh"

module tife_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`TIFE_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Event sources
	input wire tife_pkg::tife_events_type evt_i,
	input wire tife_pkg::tife_pins_type pins_i,
	// Requests and interrupt
	output tife_pkg::tife_req_type irq_req_o,
	output logic irq_o
);

	// ****************************************
	// Declarations
	// ****************************************
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_nxt;
	logic req_live;
	logic wr_go;
	logic [`TIFE_IDX_W-1:0] idx;
	logic hit_en1;
	logic hit_en2;
	logic hit_p1;
	logic hit_p2;
	logic hit_st;
	logic hit_mk;
	logic rd_take;
	logic sel_low;
	logic wr_en1;
	logic wr_en2;
	logic wr_p1;
	logic wr_p2;
	logic wr_st;
	logic wr_mk;
	logic [`TIFE_REG_W-1:0] en1_r;
	logic [`TIFE_REG_W-1:0] en2_r;
	logic [`TIFE_REG_W-1:0] p1;
	logic [`TIFE_REG_W-1:0] p2;
	logic [`TIFE_REG_W-1:0] set1;
	logic [`TIFE_REG_W-1:0] set2;
	logic [`TIFE_REG_W-1:0] clr1;
	logic [`TIFE_REG_W-1:0] clr2;
	logic [`TIFE_EVT_W-1:0] st_r;
	logic [`TIFE_EVT_W-1:0] st_nxt;
	logic [`TIFE_EVT_W-1:0] mk_r;
	logic [`TIFE_EVT_W-1:0] st_clr;
	logic [`TIFE_EVT_W-1:0] st_set;
	tife_pkg::tife_pins_type sync_a_r;
	tife_pkg::tife_pins_type sync_b_r;
	tife_pkg::tife_pins_type pin_prev_r;
	tife_pkg::tife_pins_type pin_rise;
	localparam logic [`TIFE_REG_W-1:0] p1_used = `TIFE_P1_USED;
	localparam logic [`TIFE_REG_W-1:0] p2_used = `TIFE_P2_USED;

	// ****************************************
	// Bus decode
	// ****************************************

	// Live request and committed write
	assign req_live = wb_cyc_i & wb_stb_i;
	assign rd_take = req_live & ~ack_r;
	assign sel_low = wb_sel_i[`TIFE_SEL_LOW];
	assign wr_go = req_live & wb_we_i & ack_r & sel_low;
	assign idx = wb_adr_i[`TIFE_ADR_W-1:`TIFE_IDX_LSB];

	// Register hits
	assign hit_en1 = (idx == `TIFE_IDX_ENABLE_ONE);
	assign hit_en2 = (idx == `TIFE_IDX_ENABLE_TWO);
	assign hit_p1 = (idx == `TIFE_IDX_PENDING_ONE);
	assign hit_p2 = (idx == `TIFE_IDX_PENDING_TWO);
	assign hit_st = (idx == `TIFE_IDX_EVT_STATUS);
	assign hit_mk = (idx == `TIFE_IDX_EVT_MASK);

	// Write strobes, only at the ack edge
	assign wr_en1 = wr_go & hit_en1;
	assign wr_en2 = wr_go & hit_en2;
	assign wr_p1 = wr_go & hit_p1;
	assign wr_p2 = wr_go & hit_p2;
	assign wr_st = wr_go & hit_st;
	assign wr_mk = wr_go & hit_mk;

	// Ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= rd_take;
		end
	end

	assign wb_ack_o = ack_r;

	// Read mux, unmapped reads zero
	always_comb begin
		rd_nxt = `TIFE_RST_WORD;
		if (hit_en1) begin
			rd_nxt[`TIFE_REG_W-1:0] = en1_r;
		end else if (hit_en2) begin
			rd_nxt[`TIFE_REG_W-1:0] = en2_r;
		end else if (hit_p1) begin
			rd_nxt[`TIFE_REG_W-1:0] = p1;
		end else if (hit_p2) begin
			rd_nxt[`TIFE_REG_W-1:0] = p2;
		end else if (hit_st) begin
			rd_nxt[`TIFE_EVT_W-1:0] = st_r;
		end else if (hit_mk) begin
			rd_nxt[`TIFE_EVT_W-1:0] = mk_r;
		end
	end

	// Read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= `TIFE_RST_WORD;
		end else if (rd_take) begin
			dat_r <= rd_nxt;
		end
	end

	assign wb_dat_o = dat_r;

	// ****************************************
	// Enable registers
	// ****************************************

	// Enable one byte, software owned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en1_r <= `TIFE_RST_BYTE;
		end else if (wr_en1) begin
			en1_r <= wb_dat_i[`TIFE_REG_W-1:0];
		end
	end

	// Enable two byte, software owned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en2_r <= `TIFE_RST_BYTE;
		end else if (wr_en2) begin
			en2_r <= wb_dat_i[`TIFE_REG_W-1:0];
		end
	end

	// ****************************************
	// External pin conditioning
	// ****************************************

	// Two-stage synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end else begin
			sync_a_r <= pins_i;
			sync_b_r <= sync_a_r;
		end
	end

	// Previous synchronised level
	// Resets low like the idle pins, so no false edge after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_prev_r <= '0;
		end else begin
			pin_prev_r <= sync_b_r;
		end
	end

	// Rising edges request
	assign pin_rise = sync_b_r & ~pin_prev_r;

	// ****************************************
	// Flag set sources
	// ****************************************

	// First pending register sources
	always_comb begin
		set1 = `TIFE_RST_BYTE;
		set1[`TIFE_P1_TIMER_A] = evt_i.timer_a_wrap;
		set1[`TIFE_P1_EXT_FOUR] = pin_rise.ext_request_four;
		set1[`TIFE_P1_EXT_THREE] = pin_rise.ext_request_three;
		set1[`TIFE_P1_AEC] = evt_i.async_event_counter_request;
		set1[`TIFE_P1_EXT_ONE] = pin_rise.ext_request_one;
		set1[`TIFE_P1_EXT_ZERO] = pin_rise.ext_request_zero;
	end

	// Second pending register sources
	always_comb begin
		set2 = `TIFE_RST_BYTE;
		set2[`TIFE_P2_TIMER_C] = evt_i.timer_c_overflow |
			evt_i.timer_c_underflow;
		set2[`TIFE_P2_TIMER_G] = evt_i.timer_g;
		set2[`TIFE_P2_TIMER_FH] = evt_i.timer_fh;
		set2[`TIFE_P2_TIMER_FL] = evt_i.timer_fl;
		set2[`TIFE_P2_ADC] = evt_i.adc_done;
		set2[`TIFE_P2_DIRECT] = evt_i.direct_transition;
		set2[`TIFE_P2_AEC] = evt_i.async_event_counter_request;
	end

	// Zero bits written clear flags
	assign clr1 = wr_p1 ?
		~wb_dat_i[`TIFE_REG_W-1:0] : `TIFE_RST_BYTE;
	assign clr2 = wr_p2 ?
		~wb_dat_i[`TIFE_REG_W-1:0] : `TIFE_RST_BYTE;

	// ****************************************
	// Pending flag storage
	// ****************************************

	// One sticky cell per implemented flag, empty slots read zero
	genvar gi;
	generate
		for (gi = 0; gi < `TIFE_REG_W; gi++) begin : g_one
			if (p1_used[gi]) begin : g_cell
				tife_flag_cell u_flag (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.set_i(set1[gi]),
					.clr_i(clr1[gi]),
					.flag_o(p1[gi])
				);
			end else begin : g_tie
				assign p1[gi] = 1'b0;
			end
		end
	endgenerate

	// ****************************************
	// Pending two storage
	// ****************************************

	// Same cell layout for the second register
	generate
		for (gi = 0; gi < `TIFE_REG_W; gi++) begin : g_two
			if (p2_used[gi]) begin : g_cell
				tife_flag_cell u_flag (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.set_i(set2[gi]),
					.clr_i(clr2[gi]),
					.flag_o(p2[gi])
				);
			end else begin : g_tie
				assign p2[gi] = 1'b0;
			end
		end
	endgenerate

	// ****************************************
	// Processor requests
	// ****************************************

	// First register, flag and enable both needed
	always_comb begin
		irq_req_o.timer_a = p1[`TIFE_P1_TIMER_A] &
			en1_r[`TIFE_E1_TIMER_A];
		irq_req_o.ext_four = p1[`TIFE_P1_EXT_FOUR] &
			en1_r[`TIFE_E1_EXT_FOUR];
		irq_req_o.ext_three = p1[`TIFE_P1_EXT_THREE] &
			en1_r[`TIFE_E1_EXT_THREE];
		irq_req_o.aec_one = p1[`TIFE_P1_AEC] &
			en1_r[`TIFE_E1_AEC];
		irq_req_o.ext_one = p1[`TIFE_P1_EXT_ONE] &
			en1_r[`TIFE_E1_EXT_ONE];
		irq_req_o.ext_zero = p1[`TIFE_P1_EXT_ZERO] &
			en1_r[`TIFE_E1_EXT_ZERO];
	end

	// Second register, flag and enable both needed
	always_comb begin
		irq_req_o.timer_c = p2[`TIFE_P2_TIMER_C] &
			en2_r[`TIFE_E2_TIMER_C];
		irq_req_o.timer_g = p2[`TIFE_P2_TIMER_G] &
			en2_r[`TIFE_E2_TIMER_G];
		irq_req_o.timer_fh = p2[`TIFE_P2_TIMER_FH] &
			en2_r[`TIFE_E2_TIMER_FH];
		irq_req_o.timer_fl = p2[`TIFE_P2_TIMER_FL] &
			en2_r[`TIFE_E2_TIMER_FL];
		irq_req_o.adc = p2[`TIFE_P2_ADC] &
			en2_r[`TIFE_E2_ADC];
		irq_req_o.direct = p2[`TIFE_P2_DIRECT] &
			en2_r[`TIFE_E2_DIRECT];
		irq_req_o.aec_two = p2[`TIFE_P2_AEC] &
			en2_r[`TIFE_E2_AEC];
	end

	// ****************************************
	// Event status and mask
	// ****************************************

	// Write one to clear status bits
	assign st_clr = wr_st ?
		wb_dat_i[`TIFE_EVT_W-1:0] : `TIFE_RST_EVT;

	// Both pending layouts side by side
	assign st_set = {set2, set1};

	// New events win over the clear
	assign st_nxt = (st_r & ~st_clr) | st_set;

	// Sticky event log
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= `TIFE_RST_EVT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Mask register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mk_r <= `TIFE_RST_EVT;
		end else if (wr_mk) begin
			mk_r <= wb_dat_i[`TIFE_EVT_W-1:0];
		end
	end

	// Level interrupt while any unmasked event stands
	assign irq_o = |(st_r & mk_r);

endmodule : tife_core

//--- logic/tife_params.svh
`ifndef TIFE_PARAMS_SVH
`define TIFE_PARAMS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define TIFE_ADR_W 18
`define TIFE_IDX_W 16
`define TIFE_REG_W 8
`define TIFE_EVT_W 16
`define TIFE_IDX_LSB 2
`define TIFE_SEL_LOW 0

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define TIFE_IDX_ENABLE_ONE 16'hfff3
`define TIFE_IDX_ENABLE_TWO 16'hfff4
`define TIFE_IDX_PENDING_ONE 16'hfff6
`define TIFE_IDX_PENDING_TWO 16'hfff7
`define TIFE_IDX_EVT_STATUS 16'hfff8
`define TIFE_IDX_EVT_MASK 16'hfff9

// ****************************************
// Reset values
// ****************************************
`define TIFE_RST_BYTE 8'h00
`define TIFE_RST_EVT 16'h0000
`define TIFE_RST_WORD 32'h0000_0000

// ****************************************
// Pending one flag positions
// ****************************************
`define TIFE_P1_TIMER_A 7
`define TIFE_P1_EXT_FOUR 5
`define TIFE_P1_EXT_THREE 4
`define TIFE_P1_AEC 2
`define TIFE_P1_EXT_ONE 1
`define TIFE_P1_EXT_ZERO 0
`define TIFE_P1_USED 8'hb7

// ****************************************
// Enable one bit positions
// ****************************************
`define TIFE_E1_TIMER_A 5
`define TIFE_E1_EXT_FOUR 4
`define TIFE_E1_EXT_THREE 3
`define TIFE_E1_AEC 2
`define TIFE_E1_EXT_ONE 1
`define TIFE_E1_EXT_ZERO 0

// ****************************************
// Pending two flag positions
// ****************************************
`define TIFE_P2_TIMER_C 7
`define TIFE_P2_TIMER_G 6
`define TIFE_P2_TIMER_FH 5
`define TIFE_P2_TIMER_FL 4
`define TIFE_P2_ADC 3
`define TIFE_P2_DIRECT 2
`define TIFE_P2_AEC 1
`define TIFE_P2_USED 8'hfe

// ****************************************
// Enable two bit positions
// ****************************************
`define TIFE_E2_TIMER_G 6
`define TIFE_E2_TIMER_FH 5
`define TIFE_E2_TIMER_FL 4
`define TIFE_E2_ADC 3
`define TIFE_E2_DIRECT 2
`define TIFE_E2_TIMER_C 1
`define TIFE_E2_AEC 0

`endif

//--- logic/tife_pkg.sv
package tife_pkg;

	// ****************************************
	// Event strobes from same-clock logic
	// ****************************************
	typedef struct packed {
		logic timer_a_wrap;
		logic timer_c_overflow;
		logic timer_c_underflow;
		logic async_event_counter_request;
		logic direct_transition;
		logic adc_done;
		logic timer_g;
		logic timer_fh;
		logic timer_fl;
	} tife_events_type;

	// ****************************************
	// External request pins
	// ****************************************
	typedef struct packed {
		logic ext_request_four;
		logic ext_request_three;
		logic ext_request_one;
		logic ext_request_zero;
	} tife_pins_type;

	// ****************************************
	// Gated requests toward the processor
	// ****************************************
	typedef struct packed {
		logic timer_a;
		logic ext_four;
		logic ext_three;
		logic aec_one;
		logic ext_one;
		logic ext_zero;
		logic timer_c;
		logic timer_g;
		logic timer_fh;
		logic timer_fl;
		logic adc;
		logic direct;
		logic aec_two;
	} tife_req_type;

endpackage : tife_pkg

//--- logic/tife_flag_cell.sv
`timescale 1ns/1ps
`include "tife_params.svh"

module tife_flag_cell (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Set and clear
	input wire logic set_i,
	input wire logic clr_i,
	// Flag state
	output logic flag_o
);

	logic flag_r;

	// Sticky flag, set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_r <= 1'b0;
		end else if (set_i) begin
			flag_r <= 1'b1;
		end else if (clr_i) begin
			flag_r <= 1'b0;
		end
	end

	assign flag_o = flag_r;

endmodule : tife_flag_cell

//--- bench/tife_timer_model.sv
`timescale 1ns/1ps

module tife_timer_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Count strobes
	input wire logic step_a_i,
	input wire logic step_c_i,
	input wire logic down_c_i,
	// Wrap strobes
	output logic wrap_a_o,
	output logic ovf_c_o,
	output logic unf_c_o
);
	logic [7:0] cnt_a_r;
	logic [7:0] cnt_c_r;

	// Pulses in the cycle of the wrapping step
	assign wrap_a_o = step_a_i && cnt_a_r == 8'hff;
	assign ovf_c_o = step_c_i && !down_c_i && cnt_c_r == 8'hff;
	assign unf_c_o = step_c_i && down_c_i && cnt_c_r == 8'h00;

	// Timer A counts up
	always_ff @(posedge clk_i) begin
		if (rst_i) cnt_a_r <= 8'h00;
		else if (step_a_i) cnt_a_r <= cnt_a_r + 8'h01;
	end

	// Timer C counts either way
	always_ff @(posedge clk_i) begin
		if (rst_i) cnt_c_r <= 8'h00;
		else if (step_c_i)
			cnt_c_r <= down_c_i ? cnt_c_r - 8'h01 : cnt_c_r + 8'h01;
	end
endmodule : tife_timer_model

//--- bench/tife_assertions.sv
`timescale 1ns/1ps
`include "tife_params.svh"

module tife_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`TIFE_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Events and requests
	input wire tife_pkg::tife_events_type evt_i,
	input wire tife_pkg::tife_pins_type pins_i,
	input wire tife_pkg::tife_req_type irq_req_o,
	input wire logic irq_o
);
	// ********
	// Checks
	// ********
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr_ack;
	logic tc_evt;
	assign wr_ack = wb_ack_o && wb_we_i;
	assign tc_evt = evt_i.timer_c_overflow || evt_i.timer_c_underflow;

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_upper_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_ta_rise_cause: assert property (
		$rose(irq_req_o.timer_a) |-> $past(evt_i.timer_a_wrap || wr_ack))
		else $error("timer a request rose without cause");
	a_ta_hold: assert property (
		$fell(irq_req_o.timer_a) |-> $past(wr_ack))
		else $error("timer a request fell without write");
	a_tc_rise_cause: assert property (
		$rose(irq_req_o.timer_c) |-> $past(tc_evt || wr_ack))
		else $error("timer c request rose without cause");
	a_tc_hold: assert property (
		$fell(irq_req_o.timer_c) |-> $past(wr_ack))
		else $error("timer c request fell without write");

	c_ta: cover property ($rose(irq_req_o.timer_a));
	c_tc: cover property ($rose(irq_req_o.timer_c));
	c_irq: cover property ($rose(irq_o));
endmodule : tife_assertions

bind tife_core tife_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt_i),
	.pins_i(pins_i), .irq_req_o(irq_req_o), .irq_o(irq_o));

//--- bench/timer_irq_flag_enable_bench.sv
`timescale 1ns/1ps
`include "tife_params.svh"

module timer_irq_flag_enable_bench;
	// ********
	// Signals
	// ********
	localparam logic [15:0] E1 = `TIFE_IDX_ENABLE_ONE;
	localparam logic [15:0] E2 = `TIFE_IDX_ENABLE_TWO;
	localparam logic [15:0] P1 = `TIFE_IDX_PENDING_ONE;
	localparam logic [15:0] P2 = `TIFE_IDX_PENDING_TWO;
	localparam logic [15:0] ST = `TIFE_IDX_EVT_STATUS;
	localparam logic [15:0] MK = `TIFE_IDX_EVT_MASK;
	logic clk = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [17:0] adr = 18'h0_0000;
	logic [31:0] dat = 32'h0000_0000;
	logic [3:0] sel = 4'hf;
	logic [3:0] bsel = 4'hf;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic [31:0] v;
	logic ack;
	logic irq;
	logic sa = 1'b0;
	logic sc = 1'b0;
	logic dn = 1'b0;
	logic ta_w;
	logic tc_o;
	logic tc_u;
	logic [5:0] oth = 6'h00;
	tife_pkg::tife_pins_type pins = 4'h0;
	tife_pkg::tife_req_type req;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h0000_0042;

	always #5 clk = ~clk;

	// Design and timer partner
	tife_core uut (.clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.evt_i({ta_w, tc_o, tc_u, oth}), .pins_i(pins),
		.irq_req_o(req), .irq_o(irq));
	tife_timer_model tmr (.clk_i(clk), .rst_i(rst_i), .step_a_i(sa),
		.step_c_i(sc), .down_c_i(dn), .wrap_a_o(ta_w), .ovf_c_o(tc_o),
		.unf_c_o(tc_u));

	// ********
	// Helpers
	// ********
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Enable registers keep the whole written byte
	function automatic logic [31:0] en_exp(input logic [31:0] d);
		return {24'h00_0000, d[7:0]};
	endfunction : en_exp

	task automatic check(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	// One classic cycle, bounded wait on ack
	task automatic bus(input logic w, input logic [15:0] i,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= d;
		sel <= bsel;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) mismatches++;
		#1;
	endtask : bus

	task automatic rdchk(input logic [15:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0000_0000);
		check($sformatf("reg %h", i), e, rd);
	endtask : rdchk

	task automatic step(input int n, input logic c);
		repeat (n) begin
			@(posedge clk);
			sa <= !c;
			sc <= c;
		end
		@(posedge clk);
		sa <= 1'b0;
		sc <= 1'b0;
	endtask : step

	task automatic results();
		$display("mismatches %0d samples_checked %0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// ********
	// Scenarios
	// ********
	initial begin
		repeat (5) @(posedge clk);
		rst_i <= 1'b0;
		rdchk(E1, 32'h0000_0000);
		rdchk(P1, 32'h0000_0000);
		rdchk(P2, 32'h0000_0000);
		rdchk(ST, 32'h0000_0000);
		repeat (8) begin
			v = xs();
			bus(1'b1, v[0] ? E1 : E2, v);
			rdchk(v[0] ? E1 : E2, en_exp(v));
		end
		bus(1'b1, E1, 32'h0000_0000);
		bus(1'b1, E2, 32'h0000_0000);
		step(255, 1'b0);
		rdchk(P1, 32'h0000_0000);
		step(1, 1'b0);
		rdchk(P1, 32'h0000_0080);
		check("req_ta", 1'h0, req.timer_a);
		bus(1'b1, E1, 32'h0000_0020);
		check("req_ta", 1'h1, req.timer_a);
		bus(1'b1, P1, 32'h0000_00ff);
		rdchk(P1, 32'h0000_0080);
		bus(1'b1, P1, 32'h0000_007f);
		rdchk(P1, 32'h0000_0000);
		check("req_ta", 1'h0, req.timer_a);
		bus(1'b1, E2, 32'h0000_0002);
		step(256, 1'b1);
		rdchk(P2, 32'h0000_0080);
		check("req_tc", 1'h1, req.timer_c);
		bus(1'b1, E2, 32'h0000_0000);
		check("req_tc", 1'h0, req.timer_c);
		bus(1'b1, P2, 32'h0000_007f);
		rdchk(P2, 32'h0000_0000);
		@(posedge clk);
		dn <= 1'b1;
		step(1, 1'b1);
		rdchk(P2, 32'h0000_0080);
		bus(1'b1, P2, 32'h0000_0000);
		@(posedge clk);
		oth <= 6'h3f;
		pins <= 4'hf;
		@(posedge clk);
		oth <= 6'h00;
		repeat (6) @(posedge clk);
		rdchk(P1, 32'h0000_0037);
		rdchk(P2, 32'h0000_007e);
		rdchk(ST, 32'h0000_feb7);
		check("irq", 1'h0, irq);
		bus(1'b1, MK, 32'h0000_0001);
		check("irq", 1'h1, irq);
		bus(1'b1, ST, 32'h0000_ffff);
		check("irq", 1'h0, irq);
		bus(1'b1, E1, 32'h0000_00ff);
		bus(1'b1, E2, 32'h0000_00ff);
		check("req_all", 32'h0000_0fbf, {19'h0_0000, req});
		bsel = 4'he;
		bus(1'b1, E1, 32'h0000_0000);
		bsel = 4'hf;
		rdchk(E1, 32'h0000_00ff);
		bus(1'b1, 16'h0000, 32'h0000_00ff);
		rdchk(16'h0000, 32'h0000_0000);
		results();
	end

	// Watchdog
	initial begin
		#100000;
		mismatches++;
		results();
	end
endmodule : timer_irq_flag_enable_bench
